// ===== inc/hvr_pkg.sv
package hvr_pkg;
    // Command register write codes.
    localparam logic [7:0] CMD_RD_CFG = 8'h00;
    localparam logic [7:0] CMD_RD_STA = 8'h02;
    localparam logic [7:0] CMD_WR_CFG = 8'h08;
    // Command register read-back bit positions.
    localparam int CON_BUSY_BIT = 0;
    localparam int CON_RD_OK_BIT = 1;
    localparam int CON_WR_OK_BIT = 2;
    // Configuration field positions.
    localparam int CFG_LIN_EN_BIT = 0;
    localparam int CFG_PASSIVE_BIT = 1;
    localparam int CFG_REEN_BIT = 2;
    localparam int CFG_ATTEN_BIT = 3;
    localparam int CFG_LVF_EN_BIT = 4;
    localparam logic [7:0] CFG_WR_MASK = 8'h1f;
    // Status field positions.
    localparam int STA_SHORT_BIT = 0;
    localparam int STA_LVF_BIT = 2;
    // Reset values.
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] STA_RESET = 8'h00;
    localparam logic [11:0] DAT_RESET = 12'h000;
    // Timing.
    localparam int CLK_HZ = 20_000_000;
    localparam int SHORT_MIN_NS = 20_000;
    localparam int SHORT_CYC = (SHORT_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int AUTO_BUSY_NS = 10_000;
    localparam int AUTO_BUSY_CYC = (AUTO_BUSY_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int CMD_CYC = 4;
    typedef enum logic [1:0] {HVR_IDLE, HVR_CMD, HVR_AUTO} hvr_state_t;
endpackage

// ===== verilog/hvr_regs.sv
`timescale 1ns/1ps
// Operation
// - Eight-bit configuration, reset zero, bits 7:5 reserved, bit 0 enables LIN transceiver.
// - Configuration bit 4 enables the low voltage flag function.
// - Configuration bit 3 turns on attenuator diagnostic current source.
// - Writing bit 2 re-enables a shorted-off driver; bit self-clears.
// - Bit 1 set: short sets status and interrupt, driver stays enabled.
// - Bit 1 clear: short also disables driver until re-enable write.
// - Short recognised only after persisting for 20 us (SHORT_CYC consecutive clock samples).
// - Eight-bit read-only status register, reset zero, records monitor changes.
// - Interrupt event while no command is in progress copies status into the data register automatically.
// - Status bit 0 set by short, cleared by status read.
// - Status bit 2 valid when flag enabled; 0 means supply fell below 2.1 V.
// - Enabled flag changes only on supply drop or disable.
// - Configuration not mapped; accessed through data register staging.
// - Commands 0x00 read config, 0x02 read status, 0x08 write config.
// - Command bit 0 busy; bits 1, 2 report success once idle.
// - Automatic status transfer holds busy about 10 us.
module hvr_regs
    import hvr_pkg::*;
#(
    parameter int SHORT_CYCLES = SHORT_CYC,
    parameter int AUTO_CYCLES = AUTO_BUSY_CYC
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_wdata,
    input wire logic dat_wr,
    input wire logic [7:0] dat_wdata,
    input wire logic lin_short_raw,
    input wire logic supply_low,
    input wire logic irq_en,
    output logic [7:0] cmd_rdata,
    output logic [11:0] dat_rdata,
    output logic lin_xcvr_en,
    output logic lin_drv_en,
    output logic atten_diag_en,
    output logic lvf_en,
    output logic hv_irq
);
    import hvr_pkg::*;

    // Refuses counts that the 16-bit counters cannot hold.
    if (SHORT_CYCLES < 1 || SHORT_CYCLES > 65535 ||
        AUTO_CYCLES < 1 || AUTO_CYCLES > 65535) begin : g_bad_counts
        $error("hvr_regs: cycle counts out of range.");
    end

    logic [7:0] cfg_r, cfg_nxt;
    logic [7:0] sta_r, sta_nxt;
    logic [11:0] dat_r, dat_nxt;
    logic [7:0] con_r, con_nxt;
    logic [7:0] pend_r, pend_nxt;
    logic [15:0] flt_r, flt_nxt;
    logic [15:0] tmr_r, tmr_nxt;
    logic drv_off_r, drv_off_nxt;
    logic irq_nxt;
    hvr_state_t st_r, st_nxt;
    logic short_evt;
    logic sta_read;

    // ------------------------------------------------------------
    // Short-circuit filter and command sequencer
    // ------------------------------------------------------------

    // Computes next state of all registers.
    always_comb begin
        cfg_nxt = cfg_r;
        sta_nxt = sta_r;
        dat_nxt = dat_r;
        con_nxt = con_r;
        pend_nxt = pend_r;
        tmr_nxt = tmr_r;
        drv_off_nxt = drv_off_r;
        st_nxt = st_r;
        sta_read = 1'b0;
        // A short must persist for the full filter count of cycles before it counts.
        flt_nxt = lin_short_raw ? ((flt_r < 16'(SHORT_CYCLES)) ? flt_r + 16'd1 : flt_r) : 16'd0;
        short_evt = lin_short_raw && (flt_r == 16'(SHORT_CYCLES - 1));
        // Software writes to the data register stage the low byte only.
        if (dat_wr) begin
            dat_nxt = {4'h0, dat_wdata};
        end
        // Re-enable bit is a one-cycle pulse that clears on its own.
        cfg_nxt[CFG_REEN_BIT] = 1'b0;
        unique case (st_r)
            HVR_IDLE: begin
                if (short_evt && irq_en) begin
                    st_nxt = HVR_AUTO;
                    tmr_nxt = 16'(AUTO_CYCLES - 1);
                    con_nxt = 8'h01;
                end else if (cmd_wr) begin
                    st_nxt = HVR_CMD;
                    pend_nxt = cmd_wdata;
                    tmr_nxt = 16'(CMD_CYC - 1);
                    con_nxt = 8'h01;
                end
            end
            HVR_CMD: begin
                if (tmr_r != 16'd0) begin
                    tmr_nxt = tmr_r - 16'd1;
                end else begin
                    st_nxt = HVR_IDLE;
                    unique case (pend_r)
                        CMD_RD_CFG: begin
                            dat_nxt = {pend_r[3:0], cfg_r};
                            con_nxt = 8'h02;
                        end
                        CMD_RD_STA: begin
                            dat_nxt = {pend_r[3:0], sta_r};
                            sta_read = 1'b1;
                            con_nxt = 8'h02;
                        end
                        CMD_WR_CFG: begin
                            cfg_nxt = dat_r[7:0] & CFG_WR_MASK;
                            con_nxt = 8'h04;
                        end
                        default: con_nxt = 8'h00; // Reserved code fails.
                    endcase
                end
            end
            HVR_AUTO: begin
                if (tmr_r != 16'd0) begin
                    tmr_nxt = tmr_r - 16'd1;
                end else begin
                    st_nxt = HVR_IDLE;
                    dat_nxt = {CMD_RD_STA[3:0], sta_r};
                    sta_read = 1'b1;
                    con_nxt = 8'h02;
                end
            end
        endcase
        // Status read clears the short flag; a new short wins over it.
        if (sta_read) begin
            sta_nxt[STA_SHORT_BIT] = 1'b0;
        end
        if (short_evt) begin
            sta_nxt[STA_SHORT_BIT] = 1'b1;
            if (!cfg_r[CFG_PASSIVE_BIT]) drv_off_nxt = 1'b1;
        end else if (cfg_r[CFG_REEN_BIT]) begin
            drv_off_nxt = 1'b0;
        end
        // Flag: set by the enabling write while supply is good, cleared by a drop or disable.
        if (!cfg_nxt[CFG_LVF_EN_BIT]) begin
            sta_nxt[STA_LVF_BIT] = 1'b0;
        end else if (supply_low) begin
            sta_nxt[STA_LVF_BIT] = 1'b0;
        end else if (!cfg_r[CFG_LVF_EN_BIT]) begin
            sta_nxt[STA_LVF_BIT] = 1'b1;
        end
        sta_nxt[7:3] = 5'h00;
        sta_nxt[1] = 1'b0;
        irq_nxt = irq_en && sta_nxt[STA_SHORT_BIT];
    end

    // Registers all state.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r <= CFG_RESET;
            sta_r <= STA_RESET;
            dat_r <= DAT_RESET;
            con_r <= 8'h00;
            pend_r <= 8'h00;
            flt_r <= 16'd0;
            tmr_r <= 16'd0;
            drv_off_r <= 1'b0;
            st_r <= HVR_IDLE;
            cmd_rdata <= 8'h00;
            dat_rdata <= DAT_RESET;
            lin_xcvr_en <= 1'b0;
            lin_drv_en <= 1'b0;
            atten_diag_en <= 1'b0;
            lvf_en <= 1'b0;
            hv_irq <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            sta_r <= sta_nxt;
            dat_r <= dat_nxt;
            con_r <= con_nxt;
            pend_r <= pend_nxt;
            flt_r <= flt_nxt;
            tmr_r <= tmr_nxt;
            drv_off_r <= drv_off_nxt;
            st_r <= st_nxt;
            cmd_rdata <= con_nxt;
            dat_rdata <= dat_nxt;
            lin_xcvr_en <= cfg_nxt[CFG_LIN_EN_BIT];
            lin_drv_en <= cfg_nxt[CFG_LIN_EN_BIT] && !drv_off_nxt;
            atten_diag_en <= cfg_nxt[CFG_ATTEN_BIT];
            lvf_en <= cfg_nxt[CFG_LVF_EN_BIT];
            hv_irq <= irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------

    a_reen_selfclear: assert property (@(posedge ref_clk) disable iff (!arst_n)
        cfg_r[CFG_REEN_BIT] |=> !cfg_r[CFG_REEN_BIT]) else $error("Re-enable bit stuck.");
    a_active_drv_off: assert property (@(posedge ref_clk) disable iff (!arst_n)
        short_evt && !cfg_r[CFG_PASSIVE_BIT] |=> !lin_drv_en) else $error("Driver not shut.");
    a_passive_drv_on: assert property (@(posedge ref_clk) disable iff (!arst_n)
        short_evt && cfg_r[CFG_PASSIVE_BIT] && !drv_off_r && cfg_nxt[CFG_LIN_EN_BIT] |=> lin_drv_en)
        else $error("Passive mode shut driver.");
    a_short_filter: assert property (@(posedge ref_clk) disable iff (!arst_n)
        short_evt |-> $past(lin_short_raw, 1)) else $error("Short accepted too early.");
    a_short_sets: assert property (@(posedge ref_clk) disable iff (!arst_n)
        short_evt |=> sta_r[STA_SHORT_BIT]) else $error("Short flag not set.");
    a_busy_auto: assert property (@(posedge ref_clk) disable iff (!arst_n)
        st_r == HVR_IDLE && short_evt && irq_en |=> cmd_rdata[CON_BUSY_BIT])
        else $error("Busy not raised on auto transfer.");
    a_irq_tracks: assert property (@(posedge ref_clk) disable iff (!arst_n)
        hv_irq == (irq_en && sta_r[STA_SHORT_BIT]) || $past(irq_en) != irq_en)
        else $error("Interrupt does not track flag.");
    a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
        sta_r[7:3] == 5'h00 && !cfg_r[7] && !cfg_r[6] && !cfg_r[5])
        else $error("Reserved bits set.");
    a_write_cfg: assert property (@(posedge ref_clk) disable iff (!arst_n)
        st_r == HVR_CMD && tmr_r == 16'd0 && pend_r == CMD_WR_CFG
        |=> lin_xcvr_en == $past(dat_r[0]) && cmd_rdata[CON_WR_OK_BIT])
        else $error("Config write failed.");
endmodule // hvr_regs

// ===== verif/hvr_cpu_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Processor side of the indirect access.
// ----------------------------------------
module hvr_cpu_model (
    input wire logic ref_clk,
    input wire logic [7:0] cmd_rdata,
    output logic cmd_wr,
    output logic [7:0] cmd_wdata,
    output logic dat_wr,
    output logic [7:0] dat_wdata
);
    import hvr_pkg::*;
    // Strobes stay low until a task raises them.
    initial begin
        cmd_wr = 1'b0;
        cmd_wdata = 8'h00;
        dat_wr = 1'b0;
        dat_wdata = 8'h00;
    end
    // Polls busy with a bound, so a stuck bit cannot hang the run.
    task automatic wait_idle(output bit ok);
        ok = 1'b0;
        for (int i = 0; i < 40 && !ok; i++) begin
            @(posedge ref_clk);
            #1;
            ok = (cmd_rdata[CON_BUSY_BIT] === 1'b0);
        end
    endtask
    // Waits (bounded) for idle, issues one command byte even if the wait ran out, then waits for completion.
    task automatic command(input logic [7:0] code, output bit ok);
        wait_idle(ok);
        cmd_wdata = code;
        cmd_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        cmd_wr = 1'b0;
        wait_idle(ok);
    endtask
    // Stages a byte in the data register for a later write command.
    task automatic stage(input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        dat_wdata = d;
        dat_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        dat_wr = 1'b0;
    endtask
    // Data goes first, the write command after it.
    task automatic write_cfg(input logic [7:0] d, output bit ok);
        stage(d);
        command(CMD_WR_CFG, ok);
    endtask
endmodule // hvr_cpu_model

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
// ----------------------------------------
// Register bank bench.
// ----------------------------------------
module tb_top;
    import hvr_pkg::*;
    logic ref_clk, arst_n, lin_short_raw, supply_low, irq_en, cmd_wr, dat_wr;
    logic lin_xcvr_en, lin_drv_en, atten_diag_en, lvf_en, hv_irq;
    logic [7:0] cmd_wdata, dat_wdata, cmd_rdata;
    logic [11:0] dat_rdata;
    int n_mismatch = 0;
    int n_compared = 0;
    bit ok;
    // Short counts are cut down so the run stays brief.
    hvr_regs #(.SHORT_CYCLES(4), .AUTO_CYCLES(5)) hvr_regs_inst (.ref_clk, .arst_n,
        .cmd_wr, .cmd_wdata, .dat_wr, .dat_wdata, .lin_short_raw, .supply_low, .irq_en,
        .cmd_rdata, .dat_rdata, .lin_xcvr_en, .lin_drv_en, .atten_diag_en, .lvf_en, .hv_irq);
    hvr_cpu_model hvr_cpu_model_inst (.ref_clk, .cmd_rdata, .cmd_wr, .cmd_wdata, .dat_wr,
        .dat_wdata);
    // Free-running 20 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // The sequence needs well under 2000 cycles; this bound leaves margin.
    initial begin
        #100_000;
        n_mismatch++;
        finish_test();
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wcfg(input logic [7:0] d);
        hvr_cpu_model_inst.write_cfg(d, ok);
        `CHK("wr_ok", 8'h04, cmd_rdata)
    endtask
    task automatic rd(input logic [7:0] code, input logic [11:0] exp);
        hvr_cpu_model_inst.command(code, ok);
        `CHK("rd_ok", 8'h02, cmd_rdata)
        `CHK("data", exp, dat_rdata)
    endtask
    // Main sequence: reset, access, short handling, low supply flag.
    initial begin
        arst_n = 1'b0;
        lin_short_raw = 1'b0;
        supply_low = 1'b0;
        irq_en = 1'b0;
        cyc(4);
        arst_n = 1'b1;
        `CHK("rst_cmd", 8'h00, cmd_rdata)
        `CHK("rst_dat", 12'h000, dat_rdata)
        `CHK("rst_out", 5'h00, {lin_xcvr_en, lin_drv_en, atten_diag_en, lvf_en, hv_irq})
        wcfg(8'hff);
        `CHK("outs", 5'h1e, {lin_xcvr_en, lin_drv_en, atten_diag_en, lvf_en, hv_irq})
        rd(CMD_RD_CFG, 12'h01b);
        rd(CMD_RD_STA, 12'h204);
        hvr_cpu_model_inst.command(8'h05, ok);
        `CHK("reserved", 8'h00, cmd_rdata)
        lin_short_raw = 1'b1;
        cyc(2);
        lin_short_raw = 1'b0;
        cyc(8);
        `CHK("glitch", 2'b10, {lin_drv_en, hv_irq})
        wcfg(8'h11);
        `CHK("outs2", 5'h1a, {lin_xcvr_en, lin_drv_en, atten_diag_en, lvf_en, hv_irq})
        irq_en = 1'b1;
        lin_short_raw = 1'b1;
        for (int i = 0; i < 20 && hv_irq !== 1'b1; i++) cyc(1);
        `CHK("irq", 1'b1, hv_irq)
        `CHK("busy", 1'b1, cmd_rdata[CON_BUSY_BIT])
        lin_short_raw = 1'b0;
        hvr_cpu_model_inst.wait_idle(ok);
        `CHK("auto", 12'h205, dat_rdata)
        `CHK("auto_ok", 8'h02, cmd_rdata)
        `CHK("irq_off", 2'b00, {lin_drv_en, hv_irq})
        rd(CMD_RD_STA, 12'h204);
        wcfg(8'h15);
        // The driver comes back one cycle after the re-enable bit lands.
        cyc(1);
        `CHK("reen", 1'b1, lin_drv_en)
        rd(CMD_RD_CFG, 12'h011);
        wcfg(8'h13);
        irq_en = 1'b0;
        lin_short_raw = 1'b1;
        cyc(8);
        lin_short_raw = 1'b0;
        cyc(2);
        `CHK("passive", 2'b10, {lin_drv_en, hv_irq})
        rd(CMD_RD_STA, 12'h205);
        supply_low = 1'b1;
        cyc(3);
        supply_low = 1'b0;
        rd(CMD_RD_STA, 12'h200);
        wcfg(8'h03);
        wcfg(8'h13);
        rd(CMD_RD_STA, 12'h204);
        cyc(2);
        finish_test();
    end
endmodule // tb_top
